// ### verilog/tvr_defines.svh
`ifndef TVR_DEFINES_SVH
`define TVR_DEFINES_SVH

// Delay settings count milliseconds
`define TVR_MS_NS 1000000
`define TVR_CLK_NS 8

// Line voltage selection codes
`define TVR_SEL_12 2'h0
`define TVR_SEL_23 2'h1
`define TVR_SEL_31 2'h2

// Blocking type codes
`define TVR_BLK_ALL 1'b0
`define TVR_BLK_OUT 1'b1

// Direction indices
`define TVR_DIR_RAISE 0
`define TVR_DIR_LOWER 1

// Group count and resets, 0.01 % units
`define TVR_GROUPS 8
`define TVR_TARGET_RST 16'h2710
`define TVR_BAND1_RST 16'h00c8
`define TVR_BAND2_RST 16'h0258

// Curve points that may be switched in
`define TVR_PT3 0
`define TVR_PT4 1

`endif

// ### verilog/tvr_pkg.sv
package tvr_pkg;

    // Pulse sequencer states
    typedef enum logic [1:0] {
        TVR_IDLE,
        TVR_RAISE,
        TVR_LOWER,
        TVR_WAIT
    } tvr_state_type;

    // One setting group
    typedef struct packed {
        logic [15:0] target;
        logic [15:0] raise_band1;
        logic [15:0] raise_band2;
        logic [15:0] lower_band1;
        logic [15:0] lower_band2;
    } tvr_group_type;

endpackage : tvr_pkg

// ### verilog/tvr_tap_decode.sv
`timescale 1ns/1ps
`include "tvr_defines.svh"

module tvr_tap_decode (
    input logic ref_clk, // Clock
    input logic rst_n, // Reset, active low
    input logic [15:0] loop_ch1, // Channel 1, uA
    input logic [15:0] loop_ch2, // Channel 2, uA
    input logic ch_sel, // 1 channel 2
    input logic [15:0] range_low, // Low limit, uA
    input logic [15:0] range_high, // High limit, uA
    input logic [7:0] steps_total, // Step count
    input logic high_current_high_position, // 0 inverse
    input logic scaled_mode, // Curve mode
    input logic [3:0][15:0] curve_in, // Curve inputs, uA
    input logic [3:0][7:0] curve_out, // Curve positions
    input logic [1:0] curve_use, // Points 3, 4
    output logic [7:0] tap_position // Position
);

    // Rounded interpolation
    function automatic logic [7:0] interp(input logic [15:0] x, xa, xb, input logic [7:0] ya, yb);
        logic signed [31:0] d;
        logic signed [31:0] p;
        logic signed [31:0] q;
        d = 32'(xb) - 32'(xa);
        p = (32'(x) - 32'(xa)) * (32'(yb) - 32'(ya));
        if (d <= 32'sh0) begin
            q = 32'sh0;
        end else if (p >= 32'sh0) begin
            q = (p + (d >>> 1)) / d;
        end else begin
            q = (p - (d >>> 1)) / d;
        end
        interp = 8'(32'(ya) + q);
    endfunction : interp

    logic [7:0] pos_next;
    logic [15:0] cur;
    logic [15:0] clamped;
    logic [31:0] span;
    logic [31:0] lin;
    logic [1:0] seg;
    logic [1:0] last_seg;

    // Position from loop current
    always_comb begin
        // RL19 channel one or two
        cur = ch_sel ? loop_ch2 : loop_ch1;
        clamped = cur;
        span = 32'(range_high) - 32'(range_low);
        lin = 32'h0;
        seg = 2'h0;
        last_seg = curve_use[`TVR_PT3] ? (curve_use[`TVR_PT4] ? 2'h2 : 2'h1) : 2'h0;
        if (scaled_mode) begin
            // RL18 piecewise curve
            if (cur < curve_in[0]) begin
                clamped = curve_in[0];
            end
            if (cur > curve_in[last_seg + 2'h1]) begin
                clamped = curve_in[last_seg + 2'h1];
            end
            seg = last_seg;
            for (int k = 2; k >= 0; k--) begin
                if (2'(k) <= last_seg && clamped <= curve_in[k + 1]) begin
                    seg = 2'(k);
                end
            end
            // RL22 nearest integer
            pos_next = interp(clamped, curve_in[seg], curve_in[seg + 2'h1],
                              curve_out[seg], curve_out[seg + 2'h1]);
        end else begin
            if (cur < range_low) begin
                clamped = range_low;
            end
            if (cur > range_high) begin
                clamped = range_high;
            end
            // RL16 equal current per step
            if (span != 32'h0) begin
                lin = ((32'(clamped) - 32'(range_low)) * 32'(steps_total) + (span >> 1)) / span;
            end
            // RL17 inverse option
            pos_next = high_current_high_position ? lin[7:0] : steps_total - lin[7:0];
        end
    end

    // Registered position
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_position <= 8'h00;
        end else begin
            tap_position <= pos_next;
        end
    end

endmodule : tvr_tap_decode

// ### verilog/tvr_regulator.sv
`timescale 1ns/1ps
`include "tvr_defines.svh"

// How it works
// RL1: Separate raise and lower windows
// RL2: Two stages; stage one shared delay
// RL3: Stage two definite or inverse
// RL4: Overcurrent suppresses all commands
// RL5: Block halts all or outputs only
// RL6: Eight groups, switched while running
// RL7: Automatic or manual operation
// RL8: Pulse bounded by min and max
// RL9: Tap change ends the pulse
// RL10: Max time ends pulse regardless
// RL11: Interval after pulse blocks pulses
// RL12: One line voltage is controlled
// RL13: Pair selection among three
// RL14: Single voltage on fourth channel
// RL15: Tap limits derived from settings
// RL16: Loop current linear across steps
// RL17: Inverse option maps high to low
// RL18: Piecewise curve in scaled mode
// RL19: Loop input on channel one or two
// RL20: Never raise and lower together
// RL21: Inverse delay from deviation
// RL22: Scaled position rounded to nearest
module tvr_regulator #(
    parameter int TICK_CYCLES = `TVR_MS_NS / `TVR_CLK_NS
) (
    input logic ref_clk, // Clock
    input logic rst_n, // Reset, active low
    input logic [15:0] line_voltage_first_second, // Pair 1-2
    input logic [15:0] line_voltage_second_third, // Pair 2-3
    input logic [15:0] line_voltage_third_first, // Pair 3-1
    input logic [15:0] fourth_voltage_channel, // Single input
    input logic [1:0] line_sel, // Pair select
    input logic single_voltage, // Use fourth channel
    input logic group_wr, // Group write
    input logic [2:0] group_wr_idx, // Group written
    input logic [15:0] group_wr_target, // Target
    input logic [15:0] group_wr_raise_band1, // Raise band 1
    input logic [15:0] group_wr_raise_band2, // Raise band 2
    input logic [15:0] group_wr_lower_band1, // Lower band 1
    input logic [15:0] group_wr_lower_band2, // Lower band 2
    input logic [2:0] group_sel, // Active group
    input logic [15:0] stage1_ms, // Stage 1 ms
    input logic [15:0] stage2_ms, // Stage 2 ms
    input logic inverse_time, // Inverse stage 2
    input logic [3:0] inverse_shift, // Inverse slope
    input logic auto_mode, // Automatic
    input logic manual_raise, // Raise pin
    input logic manual_lower, // Lower pin
    input logic ext_block, // Block pin
    input logic block_type, // 1 outputs only
    input logic overcurrent_active, // Overcurrent
    input logic [15:0] min_pulse_ms, // Min pulse
    input logic [15:0] max_pulse_ms, // Max pulse
    input logic [15:0] inter_pulse_ms, // Pulse gap
    input logic [7:0] steps_total, // Tap steps
    input logic [7:0] tap_center, // Centre
    input logic [15:0] step_effect, // Step effect
    input logic [15:0] loop_ch1, // Loop 1, uA
    input logic [15:0] loop_ch2, // Loop 2, uA
    input logic loop_ch_sel, // Loop select
    input logic [15:0] range_low, // Low, uA
    input logic [15:0] range_high, // High, uA
    input logic high_current_high_position, // 0 inverse
    input logic scaled_mode, // Curve mode
    input logic [3:0][15:0] curve_in, // Curve inputs
    input logic [3:0][7:0] curve_out, // Curve outputs
    input logic [1:0] curve_use, // Points 3, 4
    output logic raise_out, // Raise
    output logic lower_out, // Lower
    output logic [7:0] tap_position, // Tap position
    output logic [15:0] measured_voltage, // Measured
    output logic [23:0] tap_max_increase, // 0.01 %
    output logic [23:0] tap_max_decrease, // 0.01 %
    output logic pulse_wait, // Gap running
    output logic algo_halted // Halted
);

    tvr_pkg::tvr_state_type state_reg;
    tvr_pkg::tvr_state_type state_next;
    tvr_pkg::tvr_group_type group_reg [`TVR_GROUPS];
    tvr_pkg::tvr_group_type group_next [`TVR_GROUPS];
    tvr_pkg::tvr_group_type grp;
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] sync_prev_reg;
    logic [19:0] tick_cnt_reg;
    logic [19:0] tick_cnt_next;
    logic tick;
    logic [15:0] t1_reg [2];
    logic [15:0] t1_next [2];
    logic [16:0] t2_reg [2];
    logic [16:0] t2_next [2];
    logic [1:0] cond1;
    logic [1:0] cond2;
    logic [15:0] excess [2];
    logic [1:0] done;
    logic [15:0] ms_cnt_reg;
    logic [15:0] ms_cnt_next;
    logic moved_reg;
    logic moved_next;
    logic [7:0] pos_prev_reg;
    logic pos_change;
    logic [15:0] v_sel;
    logic [16:0] v_ext;
    logic halt;
    logic gate;
    logic blk;
    logic man_raise_edge;
    logic man_lower_edge;
    logic req_raise;
    logic req_lower;
    logic pulse_end;
    logic raise_next;
    logic lower_next;
    logic [7:0] tap_pos_dec;

    // Stage 2 step: inverse time runs faster with deviation
    function automatic logic [16:0] stage2_step(input logic inv, input logic [15:0] dev,
                                                input logic [3:0] sh);
        logic [15:0] scaled;
        scaled = dev >> sh;
        // RL21 deviation function
        stage2_step = inv ? 17'h00001 + 17'(scaled) : 17'h00001;
    endfunction : stage2_step

    // RL16 tap position decode
    tvr_tap_decode u_tap_decode (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .loop_ch1(loop_ch1),
        .loop_ch2(loop_ch2),
        .ch_sel(loop_ch_sel),
        .range_low(range_low),
        .range_high(range_high),
        .steps_total(steps_total),
        .high_current_high_position(high_current_high_position),
        .scaled_mode(scaled_mode),
        .curve_in(curve_in),
        .curve_out(curve_out),
        .curve_use(curve_use),
        .tap_position(tap_pos_dec)
    );

    // Pin synchronisers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync_prev_reg <= 3'h0;
        end else begin
            sync1_reg <= {manual_lower, manual_raise, ext_block};
            sync2_reg <= sync1_reg;
            sync_prev_reg <= sync2_reg;
        end
    end

    // Block decoding and operator edges
    always_comb begin
        blk = sync2_reg[0];
        // RL5 blocking type
        halt = blk && (block_type == `TVR_BLK_ALL);
        gate = blk && (block_type == `TVR_BLK_OUT);
        man_raise_edge = sync2_reg[1] && !sync_prev_reg[1];
        man_lower_edge = sync2_reg[2] && !sync_prev_reg[2];
    end

    // Millisecond tick; a parameter so simulations can shorten it
    always_comb begin
        tick = (tick_cnt_reg == 20'(TICK_CYCLES - 1));
        tick_cnt_next = tick ? 20'h00000 : tick_cnt_reg + 20'h00001;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= 20'h00000;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    // Setting groups; a write to the selected group takes effect on the next cycle
    always_comb begin
        for (int g = 0; g < `TVR_GROUPS; g++) begin
            group_next[g] = group_reg[g];
        end
        if (group_wr) begin
            group_next[group_wr_idx] = {group_wr_target, group_wr_raise_band1,
                                        group_wr_raise_band2, group_wr_lower_band1,
                                        group_wr_lower_band2};
        end
        // RL6 run-time group switch
        grp = group_reg[group_sel];
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int g = 0; g < `TVR_GROUPS; g++) begin
                group_reg[g] <= {`TVR_TARGET_RST, `TVR_BAND1_RST, `TVR_BAND2_RST,
                                 `TVR_BAND1_RST, `TVR_BAND2_RST};
            end
        end else begin
            group_reg <= group_next;
        end
    end

    // Measured voltage and windows
    always_comb begin
        // RL13 line pair selection
        unique case (line_sel)
            `TVR_SEL_23: v_sel = line_voltage_second_third;
            `TVR_SEL_31: v_sel = line_voltage_third_first;
            default: v_sel = line_voltage_first_second;
        endcase
        // RL14 single voltage channel
        if (single_voltage) begin
            v_sel = fourth_voltage_channel;
        end
        v_ext = {1'b0, v_sel};
        // RL1 separate raise and lower windows
        cond1[`TVR_DIR_RAISE] = v_ext + {1'b0, grp.raise_band1} < {1'b0, grp.target};
        cond2[`TVR_DIR_RAISE] = v_ext + {1'b0, grp.raise_band2} < {1'b0, grp.target};
        cond1[`TVR_DIR_LOWER] = v_ext > {1'b0, grp.target} + {1'b0, grp.lower_band1};
        cond2[`TVR_DIR_LOWER] = v_ext > {1'b0, grp.target} + {1'b0, grp.lower_band2};
        excess[`TVR_DIR_RAISE] = 16'(grp.target - grp.raise_band2 - v_sel);
        excess[`TVR_DIR_LOWER] = 16'(v_sel - grp.target - grp.lower_band2);
    end

    // Stage timers; cleared outside idle so timing restarts
    always_comb begin
        for (int d = 0; d < 2; d++) begin
            t1_next[d] = t1_reg[d];
            t2_next[d] = t2_reg[d];
            if (halt || state_reg != tvr_pkg::TVR_IDLE || !auto_mode) begin
                t1_next[d] = 16'h0000;
                t2_next[d] = 17'h00000;
            end else begin
                // RL2 shared definite delay
                if (!cond1[d]) begin
                    t1_next[d] = 16'h0000;
                end else if (tick && t1_reg[d] < stage1_ms) begin
                    t1_next[d] = t1_reg[d] + 16'h0001;
                end
                // RL3 definite or inverse time
                if (!cond2[d]) begin
                    t2_next[d] = 17'h00000;
                end else if (tick && t2_reg[d] < {1'b0, stage2_ms}) begin
                    t2_next[d] = t2_reg[d] + stage2_step(inverse_time, excess[d], inverse_shift);
                end
            end
            done[d] = (cond1[d] && t1_reg[d] >= stage1_ms)
                      || (cond2[d] && t2_reg[d] >= {1'b0, stage2_ms});
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int d = 0; d < 2; d++) begin
                t1_reg[d] <= 16'h0000;
                t2_reg[d] <= 17'h00000;
            end
        end else begin
            t1_reg <= t1_next;
            t2_reg <= t2_next;
        end
    end

    // Pulse sequencer
    always_comb begin
        state_next = state_reg;
        ms_cnt_next = ms_cnt_reg;
        moved_next = moved_reg;
        pos_change = (tap_pos_dec != pos_prev_reg);
        // RL7 automatic or manual requests
        req_raise = auto_mode ? done[`TVR_DIR_RAISE] : man_raise_edge;
        req_lower = auto_mode ? done[`TVR_DIR_LOWER] : man_lower_edge;
        // RL8 RL10 min then change, or max
        pulse_end = ((moved_reg || pos_change) && ms_cnt_reg >= min_pulse_ms)
                    || ms_cnt_reg >= max_pulse_ms;
        unique case (state_reg)
            tvr_pkg::TVR_IDLE: begin
                ms_cnt_next = 16'h0000;
                moved_next = 1'b0;
                // RL4 overcurrent suppression
                if (!halt && !overcurrent_active) begin
                    // RL20 one direction at a time
                    if (req_raise) begin
                        state_next = tvr_pkg::TVR_RAISE;
                    end else if (req_lower) begin
                        state_next = tvr_pkg::TVR_LOWER;
                    end
                end
            end
            tvr_pkg::TVR_RAISE, tvr_pkg::TVR_LOWER: begin
                // RL9 tap change ends pulse
                if (pos_change) begin
                    moved_next = 1'b1;
                end
                if (tick) begin
                    ms_cnt_next = ms_cnt_reg + 16'h0001;
                end
                if (pulse_end || halt || overcurrent_active) begin
                    state_next = tvr_pkg::TVR_WAIT;
                    ms_cnt_next = 16'h0000;
                end
            end
            tvr_pkg::TVR_WAIT: begin
                // RL11 inter-pulse interval
                if (ms_cnt_reg >= inter_pulse_ms) begin
                    state_next = tvr_pkg::TVR_IDLE;
                end else if (tick) begin
                    ms_cnt_next = ms_cnt_reg + 16'h0001;
                end
            end
        endcase
        // Output gating masks contacts; the sequencer keeps running
        raise_next = (state_next == tvr_pkg::TVR_RAISE) && !gate;
        lower_next = (state_next == tvr_pkg::TVR_LOWER) && !gate;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= tvr_pkg::TVR_IDLE;
            ms_cnt_reg <= 16'h0000;
            moved_reg <= 1'b0;
            pos_prev_reg <= 8'h00;
            raise_out <= 1'b0;
            lower_out <= 1'b0;
            pulse_wait <= 1'b0;
            algo_halted <= 1'b0;
        end else begin
            state_reg <= state_next;
            ms_cnt_reg <= ms_cnt_next;
            moved_reg <= moved_next;
            pos_prev_reg <= tap_pos_dec;
            raise_out <= raise_next;
            lower_out <= lower_next;
            pulse_wait <= (state_next == tvr_pkg::TVR_WAIT);
            algo_halted <= halt;
        end
    end

    // Status outputs; limits derived, not stored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            measured_voltage <= 16'h0000;
            tap_max_increase <= 24'h000000;
            tap_max_decrease <= 24'h000000;
            tap_position <= 8'h00;
        end else begin
            // RL12 controlled quantity
            measured_voltage <= v_sel;
            // RL15 derived tap limits
            tap_max_increase <= 24'(steps_total - tap_center) * 24'(step_effect);
            tap_max_decrease <= 24'(tap_center) * 24'(step_effect);
            tap_position <= tap_pos_dec;
        end
    end

endmodule : tvr_regulator

// ### verif/tvr_regulator_chk.sv
`timescale 1ns/1ps
module tvr_regulator_chk #(
    parameter int TICK_CYCLES = 125000
) (
    input logic ref_clk, // Clock
    input logic rst_n, // Reset, active low
    input logic raise_out, // Raise
    input logic lower_out, // Lower
    input logic pulse_wait, // Gap
    input logic algo_halted, // Halted
    input logic overcurrent_active, // Overcurrent
    input logic [15:0] min_pulse_ms, // Min pulse
    input logic [15:0] max_pulse_ms, // Max pulse
    input logic [15:0] inter_pulse_ms, // Gap
    input logic [7:0] steps_total, // Steps
    input logic [7:0] tap_center, // Centre
    input logic [15:0] step_effect, // Effect
    input logic [23:0] tap_max_increase // Increase
);
    wire busy = raise_out | lower_out;
    logic [15:0] plen_reg, plen_next, wlen_reg, wlen_next;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Run lengths in clocks, one tick of slack
    always_comb begin
        plen_next = busy ? plen_reg + 16'h0001 : 16'h0000;
        wlen_next = pulse_wait ? wlen_reg + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            plen_reg <= 16'h0000;
            wlen_reg <= 16'h0000;
        end else begin
            plen_reg <= plen_next;
            wlen_reg <= wlen_next;
        end
    end
    chk_one_direction:
        assert property (!(raise_out && lower_out)) else $error("both directions on");
    chk_oc_no_start:
        assert property ($rose(busy) |-> !$past(overcurrent_active)) else $error("start in oc");
    chk_oc_ends:
        assert property (overcurrent_active |-> ##[1:2] !busy) else $error("pulse kept in oc");
    chk_wait_quiet:
        assert property (pulse_wait |-> !busy) else $error("pulse during wait");
    chk_halt_quiet:
        assert property (algo_halted |-> !busy) else $error("pulse while halted");
    chk_max_pulse:
        assert property (plen_reg <= (max_pulse_ms + 1) * TICK_CYCLES + 2)
        else $error("pulse too long");
    chk_min_pulse:
        assert property ($fell(busy) && !overcurrent_active && !algo_halted
            |-> plen_reg + TICK_CYCLES >= min_pulse_ms * TICK_CYCLES) else $error("pulse short");
    chk_inter_gap:
        assert property ($fell(pulse_wait) |-> wlen_reg + TICK_CYCLES >= inter_pulse_ms
            * TICK_CYCLES) else $error("wait short");
    chk_limit_calc:
        assert property (1 |=> tap_max_increase == $past(24'(steps_total - tap_center)
            * step_effect)) else $error("bad increase");
    cover property ($rose(raise_out));
    cover property ($rose(lower_out));
    cover property ($fell(pulse_wait));
    cover property ($rose(algo_halted));
endmodule : tvr_regulator_chk
bind tvr_regulator tvr_regulator_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// ### verif/tvr_tap_model.sv
`timescale 1ns/1ps
module tvr_tap_model #(
    parameter int MOVE_CYCLES = 15
) (
    input logic ref_clk, // Clock
    input logic rst_n, // Reset, active low
    input logic raise_out, // Raise
    input logic lower_out, // Lower
    input logic stuck, // Jammed
    output logic [15:0] loop_ua // Transmitter current, uA
);
    logic [7:0] pos_reg, pos_next, run_reg, run_next;
    // One step per pulse, after a run-up
    always_comb begin
        run_next = (raise_out | lower_out) ? run_reg + 8'h01 : 8'h00;
        pos_next = pos_reg;
        if (run_reg == 8'(MOVE_CYCLES) && !stuck)
            pos_next = raise_out ? pos_reg + 8'h01 : pos_reg - 8'h01;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_reg <= 8'h05;
            run_reg <= 8'h00;
        end else begin
            pos_reg <= pos_next;
            run_reg <= run_next;
        end
    end
    // one mA a step, normal sense
    assign loop_ua = 16'h0fa0 + 16'h03e8 * 16'(pos_reg);
endmodule : tvr_tap_model

// ### verif/tvr_regulator_tb.sv
`timescale 1ns/1ps
module tvr_regulator_tb;
    logic ref_clk, rst_n, single_voltage, group_wr, inverse_time, auto_mode, manual_raise;
    logic manual_lower, ext_block, block_type, overcurrent_active, loop_ch_sel, scaled_mode;
    logic high_current_high_position, raise_out, lower_out, pulse_wait, algo_halted, stuck;
    logic [15:0] line_voltage_first_second, line_voltage_second_third, line_voltage_third_first;
    logic [15:0] fourth_voltage_channel, group_wr_target, group_wr_raise_band1, loop_ua;
    logic [15:0] group_wr_raise_band2, group_wr_lower_band1, group_wr_lower_band2, stage1_ms;
    logic [15:0] stage2_ms, min_pulse_ms, max_pulse_ms, inter_pulse_ms, step_effect, loop_ch1;
    logic [15:0] loop_ch2, range_low, range_high, measured_voltage;
    logic [1:0] line_sel, curve_use;
    logic [2:0] group_wr_idx, group_sel;
    logic [3:0] inverse_shift;
    logic [7:0] steps_total, tap_center, tap_position;
    logic [3:0][15:0] curve_in;
    logic [3:0][7:0] curve_out;
    logic [23:0] tap_max_increase, tap_max_decrease;
    logic [15:0] exp_v [5] = '{16'h2711, 16'h2712, 16'h2713, 16'h2711, 16'h2714};
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    tvr_regulator #(.TICK_CYCLES(10)) uut (.*);
    tvr_tap_model u_tap (.ref_clk(ref_clk), .rst_n(rst_n), .raise_out(raise_out),
        .lower_out(lower_out), .stuck(stuck), .loop_ua(loop_ua));
    // Unused channel shows a wrong position
    assign loop_ch1 = loop_ch_sel ? 16'h4e20 : loop_ua;
    assign loop_ch2 = loop_ch_sel ? loop_ua : 16'h0fa0;
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish();
        if (n_fail == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    // Demand, time answer and pulse, let the gap end
    task automatic pulse(input logic [15:0] v, input int wlo, whi, llo, lhi, input logic dn);
        int w;
        int len;
        line_voltage_first_second = v;
        for (w = 0; w < 600 && (raise_out | lower_out) !== 1'b1; w++) cyc(1);
        chk(24'(w >= wlo && w <= whi), 24'h1);
        chk(24'({raise_out, lower_out}), dn ? 24'h1 : 24'h2);
        for (len = 0; len < 600 && (raise_out | lower_out) === 1'b1; len++) cyc(1);
        chk(24'(len >= llo && len <= lhi), 24'h1);
        chk(24'(pulse_wait), 24'h1);
        line_voltage_first_second = 16'h2710;
        for (w = 0; w < 600 && pulse_wait === 1'b1; w++) cyc(1);
    endtask : pulse
    // A hang counts as a mismatch
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        rst_n = 1'b0;
        {single_voltage, group_wr, inverse_time, manual_raise, manual_lower, stuck} = '0;
        {ext_block, block_type, overcurrent_active, loop_ch_sel, scaled_mode} = '0;
        {curve_in, curve_out, curve_use, line_sel, group_sel, group_wr_idx, inverse_shift} = '0;
        {auto_mode, high_current_high_position} = 2'h3;
        {line_voltage_first_second, line_voltage_second_third} = {16'h2711, 16'h2712};
        {line_voltage_third_first, fourth_voltage_channel} = {16'h2713, 16'h2714};
        {group_wr_target, group_wr_raise_band1, group_wr_lower_band1} = {16'h2000, {2{16'h00c8}}};
        {group_wr_raise_band2, group_wr_lower_band2} = {2{16'h0258}};
        {stage1_ms, stage2_ms, min_pulse_ms, max_pulse_ms} = {16'h2, 16'h3, 16'h3, 16'h8};
        {inter_pulse_ms, step_effect, range_low, range_high} = {16'h4, 16'ha7, 16'hfa0, 16'h4e20};
        {steps_total, tap_center} = {8'h10, 8'h08};
        cyc(10);
        rst_n = 1'b1;
        cyc(3);
        chk(tap_max_increase, 24'h000538);
        tap_center = 8'h05;
        cyc(3);
        chk(tap_max_decrease, 24'h000343);
        for (int i = 0; i < 5; i++) begin
            line_sel = 2'(i);
            single_voltage = (i == 4);
            cyc(3);
            chk(24'(measured_voltage), 24'(exp_v[i]));
        end
        single_voltage = 1'b0;
        chk(24'(tap_position), 24'h5);
        loop_ch_sel = 1'b1;
        cyc(4);
        chk(24'(tap_position), 24'h5);
        high_current_high_position = 1'b0;
        cyc(4);
        chk(24'(tap_position), 24'hb);
        {high_current_high_position, loop_ch_sel} = 2'h2;
        pulse(16'h2647, 8, 26, 18, 34, 1'b0);
        chk(24'(tap_position), 24'h6);
        stuck = 1'b1;
        pulse(16'h27d9, 8, 26, 68, 84, 1'b1);
        {stuck, stage1_ms} = {1'b0, 16'h28};
        pulse(16'h24b7, 18, 36, 18, 34, 1'b0);
        inverse_time = 1'b1;
        pulse(16'h2000, 0, 13, 18, 34, 1'b0);
        {inverse_time, stage1_ms, overcurrent_active} = {1'b0, 16'h2, 1'b1};
        line_voltage_first_second = 16'h2647;
        cyc(60);
        chk(24'(raise_out), 24'h0);
        overcurrent_active = 1'b0;
        pulse(16'h2647, 0, 26, 18, 34, 1'b0);
        {ext_block, line_voltage_first_second} = {1'b1, 16'h2647};
        cyc(60);
        chk(24'({algo_halted, raise_out}), 24'h2);
        ext_block = 1'b0;
        pulse(16'h2647, 8, 30, 18, 34, 1'b0);
        {block_type, ext_block, line_voltage_first_second} = {2'h3, 16'h2647};
        for (int w = 0; w < 300 && pulse_wait !== 1'b1; w++) cyc(1);
        chk(24'({pulse_wait, algo_halted, raise_out}), 24'h4);
        {block_type, ext_block, line_voltage_first_second, auto_mode} = {2'h0, 16'h2647, 1'b0};
        cyc(200);
        chk(24'(raise_out), 24'h0);
        manual_lower = 1'b1;
        pulse(16'h2647, 1, 10, 18, 34, 1'b1);
        {manual_lower, auto_mode, group_wr_idx, group_wr} = {1'b0, 1'b1, 3'h3, 1'b1};
        cyc(1);
        {group_wr, group_sel} = {1'b0, 3'h3};
        pulse(16'h2710, 5, 40, 18, 34, 1'b1);
        group_sel = 3'h0;
        cyc(2);
        chk(24'(tap_position), 24'h8);
        {curve_in, curve_out, curve_use, scaled_mode} = {64'h4e2030d421340fa0, 32'h120c0700, 3'h7};
        cyc(3);
        chk(24'(tap_position), 24'h0b);
        tally_and_finish();
    end
endmodule : tvr_regulator_tb
